// *** hdl/ast_pkg.sv ***
package ast_pkg;

  // ****************************************************************
  // bit timing, in periods of the 16x clocks
  // ****************************************************************
  localparam logic [3:0] AST_TICK_LAST = 4'hF;  // sixteenth tick ends a bit
  localparam logic [3:0] AST_TICK_MID  = 4'h7;  // eighth tick, start recheck

  // ****************************************************************
  // character format
  // ****************************************************************
  localparam logic [3:0] AST_BASE_BITS = 4'h5;  // length select 00
  localparam int         AST_CHAR_W    = 8;
  localparam int         AST_FRAME_W   = 12;    // 8 data, parity, 2 stop, one spare

  // ****************************************************************
  // register port map (byte addresses)
  // ****************************************************************
  localparam int         AST_ADDR_W    = 4;
  localparam int         AST_DATA_W    = 8;
  localparam logic [3:0] AST_ADDR_STAT = 4'h0;  // sticky events, write one clears
  localparam logic [3:0] AST_ADDR_MASK = 4'h4;  // event mask
  localparam logic [3:0] AST_ADDR_LIVE = 4'h8;  // live state, read only
  localparam logic [3:0] AST_ADDR_RXD  = 4'hC;  // receive holding register

  // event bits of status and mask
  localparam int         AST_EV_W      = 2;
  localparam int         AST_EV_RX     = 0;     // character received
  localparam int         AST_EV_TX     = 1;     // character sent
  localparam logic [1:0] AST_EV_RST    = 2'h0;

  // live state bits
  localparam int         AST_LV_TX_BUFFER_EMPTY   = 0;
  localparam int         AST_LV_EOC    = 1;
  localparam int         AST_LV_DA     = 2;
  localparam int         AST_LV_PERR   = 3;
  localparam int         AST_LV_TXD    = 4;

  // data bits per character from the two length selects
  function automatic logic [3:0] ast_char_bits(input logic [1:0] sel);
    ast_char_bits = AST_BASE_BITS + {2'h0, sel};
  endfunction : ast_char_bits

  // parity bit over a character; odd unless even is selected
  function automatic logic ast_parity(input logic [7:0] d, input logic even_sel);
    ast_parity = (^d) ^ ~even_sel;
  endfunction : ast_parity

  // bits on the line after the start bit: data, optional parity, stops
  function automatic logic [3:0] ast_frame_bits(input logic [1:0] sel,
                                                input logic       par_off,
                                                input logic       two_stop);
    ast_frame_bits = ast_char_bits(sel) + {3'h0, ~par_off} + {3'h0, two_stop} + 4'h1;
  endfunction : ast_frame_bits

endpackage : ast_pkg

// *** hdl/ast_rx.sv ***
`timescale 1ns/1ps
module ast_rx
  import ast_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       line,
  input  wire logic [1:0] len_sel,
  input  wire logic       par_off,
  input  wire logic       par_even,
  input  wire logic       two_stop,
  output logic      [7:0] char_q,
  output logic            perr_q,
  output logic            done_q,
  output logic            busy
);
  import ast_pkg::*;

  typedef enum logic [1:0] {AST_RX_IDLE, AST_RX_START, AST_RX_BITS, AST_RX_XFER} ast_rx_st_type;

  typedef struct packed {
    ast_rx_st_type st;
    logic [3:0]    cnt;
    logic [3:0]    idx;
    logic [7:0]    shift;
    logic          perr_cur;
    logic [7:0]    hold;
    logic          perr;
    logic          done;
  } ast_rx_state_type;

  ast_rx_state_type s_q, s_d;
  logic [3:0] nbits;
  logic [3:0] last;

  assign nbits  = ast_char_bits(len_sel);
  assign last   = ast_frame_bits(len_sel, par_off, two_stop) - 4'h1;
  assign char_q = s_q.hold;
  assign perr_q = s_q.perr;
  assign done_q = s_q.done;
  assign busy   = (s_q.st != AST_RX_IDLE);

  // ****************************************************************
  // receive sequencer, advanced only on 16x ticks
  // ****************************************************************
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    // a stale error from a parity frame must not outlive a switch to no parity
    if (par_off) begin
      s_d.perr = 1'b0;
    end
    if (tick) begin
      case (s_q.st)
        AST_RX_IDLE: begin
          if (!line) begin  // mark-to-space edge
            s_d.st    = AST_RX_START;
            s_d.cnt   = 4'h0;
            s_d.shift = 8'h00;  // keeps unused upper bits low
          end
        end
        AST_RX_START: begin
          s_d.cnt = s_q.cnt + 4'h1;
          if (s_q.cnt == AST_TICK_MID) begin
            // a noise spike has gone by mid-bit, so drop it
            s_d.st  = line ? AST_RX_IDLE : AST_RX_BITS;
            s_d.cnt = 4'h0;
            s_d.idx = 4'h0;
          end
        end
        AST_RX_BITS: begin
          s_d.cnt = s_q.cnt + 4'h1;
          if (s_q.cnt == AST_TICK_LAST) begin  // bit centre
            if (s_q.idx < nbits) begin
              s_d.shift[s_q.idx[2:0]] = line;  // lsb first
            end else if (!par_off && s_q.idx == nbits) begin
              s_d.perr_cur = (line != ast_parity(s_q.shift, par_even));
            end
            s_d.idx = s_q.idx + 4'h1;
            if (s_q.idx == last) begin
              s_d.st = AST_RX_XFER;
            end
          end
        end
        AST_RX_XFER: begin
          // one tick after the last stop sample the character moves
          s_d.st   = AST_RX_IDLE;
          s_d.hold = s_q.shift;
          s_d.perr = par_off ? 1'b0 : s_q.perr_cur;
          s_d.done = 1'b1;
          s_d.perr_cur = 1'b0;
        end
        default: begin
          s_d.st = AST_RX_IDLE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{st: AST_RX_IDLE, cnt: 4'h0, idx: 4'h0, shift: 8'h00, perr_cur: 1'b0,
               hold: 8'h00, perr: 1'b0, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

endmodule : ast_rx

// *** hdl/ast_uart.sv ***
`timescale 1ns/1ps
module ast_uart (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // register port
  input  wire logic [ast_pkg::AST_ADDR_W-1:0] reg_addr,
  input  wire logic [ast_pkg::AST_DATA_W-1:0] reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [ast_pkg::AST_DATA_W-1:0] reg_rdata,
  output logic                               irq,
  // device pins
  input  wire logic                          master_reset,
  input  wire logic                          tx_clk_16x,
  input  wire logic                          rx_clk_16x,
  input  wire logic                          tx_load_strobe,
  input  wire logic [7:0]                    tx_parallel_in,
  input  wire logic                          fmt_load_strobe,
  input  wire logic                          parity_disable,
  input  wire logic                          even_parity_sel,
  input  wire logic                          stop_bits_two,
  input  wire logic                          char_len_sel_hi,
  input  wire logic                          char_len_sel_lo,
  input  wire logic                          rx_serial_in,
  input  wire logic                          rx_ready_clear,
  input  wire logic                          rx_output_enable_n,
  output logic                               tx_serial_out,
  output logic                               tx_buffer_empty,
  output logic                               tx_done,
  output logic                               rx_char_ready,
  output logic                               parity_error_flag,
  output logic      [7:0]                    rx_parallel_out,
  output logic                               rx_parallel_oe
);
  import ast_pkg::*;

  // ****************************************************************
  // state of the transmitter, receiver flags and outputs, format holding and register port
  // ****************************************************************
  typedef struct packed {
    logic                       tck_prev;
    logic                       rck_prev;
    logic                       ds_prev;
    logic [1:0]                 len_sel;
    logic                       par_off;
    logic                       par_even;
    logic                       two_stop;
    logic [7:0]                 hold;
    logic                       hold_full;
    logic                       busy;
    logic [AST_FRAME_W-1:0]     frame;
    logic [3:0]                 nframe;
    logic [3:0]                 idx;
    logic [3:0]                 cnt;
    logic                       line;
    logic                       eoc;
    logic                       da;
    logic [7:0]                 rx_out;
    logic                       rx_oe;
    logic [AST_EV_W-1:0]        status;
    logic [AST_EV_W-1:0]        mask;
    logic [AST_DATA_W-1:0]      rdata;
  } ast_state_type;

  localparam ast_state_type AST_RST = '{
    tck_prev: 1'b0, rck_prev: 1'b0, ds_prev: 1'b0, len_sel: 2'h0, par_off: 1'b0,
    par_even: 1'b0, two_stop: 1'b0, hold: 8'h00, hold_full: 1'b0, busy: 1'b0,
    frame: 12'hFFF, nframe: 4'h0, idx: 4'h0, cnt: 4'h0, line: 1'b1, eoc: 1'b1,
    da: 1'b0, rx_out: 8'h00, rx_oe: 1'b0, status: AST_EV_RST, mask: AST_EV_RST,
    rdata: 8'h00};

  ast_state_type s_q, s_d;
  logic          core_rst;
  logic          tx_tick;
  logic          rx_tick;
  logic [7:0]    rx_char;
  logic          rx_perr;
  logic          rx_done;
  logic [3:0]    tx_nbits;

  // the pin reset and the system reset clear the same state
  assign core_rst = sys_rst | master_reset;
  // 16x clocks arrive synchronous, so a rising edge becomes a tick
  assign tx_tick  = tx_clk_16x & ~s_q.tck_prev;
  assign rx_tick  = rx_clk_16x & ~s_q.rck_prev;
  assign tx_nbits = ast_char_bits(s_q.len_sel);

  // ****************************************************************
  // receiver
  // ****************************************************************
  ast_rx u_rx (
    .clk      (clk),
    .rst      (core_rst),
    .tick     (rx_tick),
    .line     (rx_serial_in),
    .len_sel  (s_q.len_sel),
    .par_off  (s_q.par_off),
    .par_even (s_q.par_even),
    .two_stop (s_q.two_stop),
    .char_q   (rx_char),
    .perr_q   (rx_perr),
    .done_q   (rx_done),
    .busy     ()
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [AST_EV_W-1:0] ev;
    logic [7:0]          dmask;
    ev            = '0;
    dmask         = 8'h00;
    s_d           = s_q;
    s_d.tck_prev  = tx_clk_16x;
    s_d.rck_prev  = rx_clk_16x;
    s_d.ds_prev   = tx_load_strobe;

    // format holding follows the inputs while its strobe is high
    if (fmt_load_strobe) begin
      s_d.len_sel  = {char_len_sel_hi, char_len_sel_lo};
      s_d.par_off  = parity_disable;
      s_d.par_even = even_parity_sel;
      s_d.two_stop = stop_bits_two;
    end

    // a strobe while the holding register is full overwrites it
    if (tx_load_strobe && !s_q.ds_prev) begin
      s_d.hold      = tx_parallel_in;
      s_d.hold_full = 1'b1;
    end

    // transmitter: start one tick after load, then frame bits
    if (tx_tick) begin
      if (!s_q.busy && s_q.hold_full) begin
        for (int i = 0; i < AST_CHAR_W; i++) begin
          dmask[i] = (i < int'(tx_nbits)) ? s_q.hold[i] : 1'b0;
        end
        for (int i = 0; i < AST_FRAME_W; i++) begin
          if (i < int'(tx_nbits)) begin
            s_d.frame[i] = dmask[i[2:0]];
          end else if (!s_q.par_off && i == int'(tx_nbits)) begin
            s_d.frame[i] = ast_parity(dmask, s_q.par_even);
          end else begin
            s_d.frame[i] = 1'b1;  // stop bits
          end
        end
        s_d.nframe    = ast_frame_bits(s_q.len_sel, s_q.par_off, s_q.two_stop);
        s_d.hold_full = (tx_load_strobe && !s_q.ds_prev);
        s_d.busy      = 1'b1;
        s_d.line      = 1'b0;  // start bit
        s_d.eoc       = 1'b0;
        s_d.cnt       = 4'h0;
        s_d.idx       = 4'h0;
      end else if (s_q.busy) begin
        s_d.cnt = s_q.cnt + 4'h1;
        if (s_q.cnt == AST_TICK_LAST) begin
          if (s_q.idx == s_q.nframe) begin
            s_d.busy = 1'b0;
            s_d.line = 1'b1;
            s_d.eoc  = 1'b1;
            ev[AST_EV_TX] = 1'b1;
          end else begin
            s_d.line = s_q.frame[s_q.idx];
            s_d.idx  = s_q.idx + 4'h1;
          end
        end
      end
    end

    // ready flag: a new character wins over a clear in the same cycle
    if (!rx_ready_clear) begin
      s_d.da = 1'b0;
    end
    if (rx_done) begin
      s_d.da         = 1'b1;
      ev[AST_EV_RX]  = 1'b1;
    end

    // shared outputs: registered so the data pins come from flops
    s_d.rx_out = rx_char;
    s_d.rx_oe  = ~rx_output_enable_n;

    // register port, answer the cycle after the read strobe
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        AST_ADDR_STAT: s_d.rdata = {6'h00, s_q.status};
        AST_ADDR_MASK: s_d.rdata = {6'h00, s_q.mask};
        AST_ADDR_LIVE: begin
          s_d.rdata[AST_LV_TX_BUFFER_EMPTY] = ~s_q.hold_full;
          s_d.rdata[AST_LV_EOC]  = s_q.eoc;
          s_d.rdata[AST_LV_DA]   = s_q.da;
          s_d.rdata[AST_LV_PERR] = rx_perr;
          s_d.rdata[AST_LV_TXD]  = s_q.line;
        end
        AST_ADDR_RXD:  s_d.rdata = rx_char;
        default:       s_d.rdata = 8'h00;  // unmapped reads as zero
      endcase
    end
    if (reg_wr && reg_addr == AST_ADDR_MASK) begin
      s_d.mask = reg_wdata[AST_EV_W-1:0];
    end
    // write one clears, but an event in the same cycle survives
    if (reg_wr && reg_addr == AST_ADDR_STAT) begin
      s_d.status = s_q.status & ~reg_wdata[AST_EV_W-1:0];
    end
    s_d.status = s_d.status | ev;
  end

  // state register; reset puts the line and both flags at mark
  always_ff @(posedge clk) begin
    if (core_rst) begin
      s_q <= AST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata         = s_q.rdata;
  assign irq               = |(s_q.status & s_q.mask);
  assign tx_serial_out     = s_q.line;
  assign tx_buffer_empty   = ~s_q.hold_full;
  assign tx_done           = s_q.eoc;
  assign rx_char_ready     = s_q.da;
  assign parity_error_flag = rx_perr;  // clamped low in the receiver
  assign rx_parallel_out   = s_q.rx_out;
  assign rx_parallel_oe    = s_q.rx_oe;

endmodule : ast_uart

// *** test/ast_uart_checker.sv ***
`timescale 1ns/1ps
module ast_uart_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic master_reset,
  input wire logic tx_clk_16x,
  input wire logic tx_load_strobe,
  input wire logic fmt_load_strobe,
  input wire logic parity_disable,
  input wire logic rx_ready_clear,
  input wire logic rx_output_enable_n,
  input wire logic tx_serial_out,
  input wire logic tx_buffer_empty,
  input wire logic tx_done,
  input wire logic rx_char_ready,
  input wire logic parity_error_flag,
  input wire logic rx_parallel_oe
);
  // ****************
  // tick count between line changes
  // ****************
  logic       rst_any;
  logic       tick;
  logic       clk16_q;
  logic       line_q;
  logic [7:0] tick_cnt_q;
  default clocking @(posedge clk); endclocking
  assign rst_any = sys_rst || master_reset;
  assign tick    = tx_clk_16x && !clk16_q;
  // a fixed offset from tick to line cancels out, so only whole bits count
  always_ff @(posedge clk) begin
    clk16_q <= tx_clk_16x;
    line_q  <= tx_serial_out;
    if (rst_any || tx_serial_out != line_q) begin
      tick_cnt_q <= 8'h00;
    end else begin
      tick_cnt_q <= tick_cnt_q + {7'h00, tick};
    end
  end
  property p_reset;
    rst_any |=> tx_serial_out && tx_buffer_empty && tx_done && !rx_char_ready;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_load;
    disable iff (rst_any) $rose(tx_load_strobe) |=> !tx_buffer_empty;
  endproperty
  a_load: assert property (p_load) else $error("load not taken");
  property p_done_fall;
    disable iff (rst_any) $fell(tx_done) |-> !tx_serial_out && $past(tx_serial_out);
  endproperty
  a_done_fall: assert property (p_done_fall) else $error("done fell off start");
  property p_idle_mark;
    disable iff (rst_any) tx_done |-> tx_serial_out;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("idle line not mark");
  property p_par_off;
    disable iff (rst_any) fmt_load_strobe && parity_disable |=> ##1 !parity_error_flag;
  endproperty
  a_par_off: assert property (p_par_off) else $error("parity error not clamped");
  property p_ready_clr;
    disable iff (rst_any) !rx_ready_clear [*3] |-> !rx_char_ready;
  endproperty
  a_ready_clr: assert property (p_ready_clr) else $error("ready not cleared");
  property p_oe_off;
    disable iff (rst_any) rx_output_enable_n [*2] |-> !rx_parallel_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("outputs driven when off");
  property p_bit_len;
    disable iff (rst_any) (tx_serial_out != line_q) && !tx_done && !$past(tx_done)
      |-> ((tick_cnt_q + {7'h00, tick}) & 8'h0F) == 8'h00;
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit not 16 ticks");
endmodule : ast_uart_checker

bind ast_uart ast_uart_checker u_chk (.clk, .sys_rst, .master_reset, .tx_clk_16x,
  .tx_load_strobe, .fmt_load_strobe, .parity_disable, .rx_ready_clear, .rx_output_enable_n,
  .tx_serial_out, .tx_buffer_empty, .tx_done, .rx_char_ready, .parity_error_flag,
  .rx_parallel_oe);

// *** test/ast_term.sv ***
`timescale 1ns/1ps
module ast_term (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [11:0] frame,
  input  wire logic [3:0]  nbits,
  output logic             line,
  output logic             tx_clk,
  output logic             rx_clk,
  output logic             busy
);
  // ****************
  // serial terminal model
  // ****************
  logic [1:0]  div_q  = 2'h0;
  logic [12:0] sr_q   = 13'h1FFF;
  logic [3:0]  left_q = 4'h0;
  logic [5:0]  ph_q   = 6'h0;
  // free running 16x clocks, four cycles each, out of phase
  always_ff @(posedge clk) begin
    div_q <= div_q + 2'h1;
  end
  assign rx_clk = div_q[1];
  assign tx_clk = div_q[1] ^ div_q[0];
  // one bit per 64 cycles; phase against the ticks is left arbitrary
  always_ff @(posedge clk) begin
    if (go && left_q == 4'h0) begin
      sr_q   <= {frame, 1'b0};
      left_q <= nbits + 4'h1;
      ph_q   <= 6'h0;
    end else if (left_q != 4'h0) begin
      ph_q <= ph_q + 6'h1;
      if (ph_q == 6'h3F) begin
        sr_q   <= {1'b1, sr_q[12:1]};
        left_q <= left_q - 4'h1;
      end
    end
  end
  // mark between characters
  assign line = (left_q != 4'h0) ? sr_q[0] : 1'b1;
  assign busy = left_q != 4'h0;
endmodule : ast_term

// *** test/ast_uart_tb_top.sv ***
`timescale 1ns/1ps
module ast_uart_tb_top;
  import ast_pkg::*;
  // ****************
  // stimulus and instances
  // ****************
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, master_reset = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, tx_parallel_in = 8'h00, reg_rdata, rx_parallel_out;
  logic tx_load_strobe = 1'b0, fmt_load_strobe = 1'b0, parity_disable = 1'b0;
  logic even_parity_sel = 1'b0, stop_bits_two = 1'b0, char_len_sel_hi = 1'b0;
  logic char_len_sel_lo = 1'b0, rx_ready_clear = 1'b1, rx_output_enable_n = 1'b0;
  logic irq, tx_clk_16x, rx_clk_16x, tx_serial_out, tx_buffer_empty, tx_done;
  logic rx_char_ready, parity_error_flag, rx_parallel_oe, term_line, term_busy;
  logic term_go = 1'b0, glitch_n = 1'b1;
  logic [11:0] term_frame = 12'hFFF;
  logic [3:0]  term_bits = 4'h0;
  int mismatches = 0;
  int num_checks = 0;
  wire rx_serial_in = term_line & glitch_n;
  always #2.5 clk = ~clk;
  ast_uart u_dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .master_reset, .tx_clk_16x, .rx_clk_16x, .tx_load_strobe, .tx_parallel_in,
    .fmt_load_strobe, .parity_disable, .even_parity_sel, .stop_bits_two, .char_len_sel_hi,
    .char_len_sel_lo, .rx_serial_in, .rx_ready_clear, .rx_output_enable_n, .tx_serial_out,
    .tx_buffer_empty, .tx_done, .rx_char_ready, .parity_error_flag, .rx_parallel_out,
    .rx_parallel_oe);
  ast_term u_term (.clk, .go(term_go), .frame(term_frame), .nbits(term_bits),
    .line(term_line), .tx_clk(tx_clk_16x), .rx_clk(rx_clk_16x), .busy(term_busy));
  // ****************
  // helpers
  // ****************
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task automatic hang();
    chk(1'b0, "wait expired");
    results();
  endtask : hang
  // sample a settled cycle, clear of the edge's own updates
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk) reg_rd <= 1'b0;
    #1;
    chk(reg_rdata === e, "reg read");
  endtask : rd
  task automatic set_fmt(input logic [1:0] len, input logic np, input logic two, input logic ev);
    @(posedge clk);
    {char_len_sel_hi, char_len_sel_lo} <= len;
    parity_disable <= np;
    stop_bits_two <= two;
    even_parity_sel <= ev;
    fmt_load_strobe <= 1'b1;
    @(posedge clk) fmt_load_strobe <= 1'b0;
  endtask : set_fmt
  // expected frame after the start bit, spare positions at mark
  function automatic logic [11:0] mk(input logic [1:0] len, input logic np, input logic ev,
      input logic bad, input logic [7:0] d, input logic two, output int n);
    logic [11:0] f;
    logic [7:0]  m;
    m = d & (8'hFF >> (2'd3 - len));
    f = 12'hFFF;
    n = 5 + len;
    for (int i = 0; i < 8; i++) if (i < n) f[i] = m[i];
    if (!np) f[n] = (ev ? ^m : ~^m) ^ bad;
    n = n + (np ? 1 : 2) + two;
    mk = f;
  endfunction : mk
  // ****************
  // scenarios
  // ****************
  task automatic t_tx(input logic [1:0] len, input logic np, input logic two, input logic ev,
      input logic [7:0] d);
    logic [12:0] s;
    int n;
    int k;
    s = {mk(len, np, ev, 1'b0, d, two, n), 1'b0};
    set_fmt(len, np, two, ev);
    @(posedge clk);
    {char_len_sel_hi, char_len_sel_lo} <= ~len;
    tx_parallel_in <= d;
    tx_load_strobe <= 1'b1;
    @(posedge clk) tx_load_strobe <= 1'b0;
    for (k = 0; k < 40 && tx_serial_out !== 1'b0; k++) cyc(1);
    if (k == 40) hang();
    chk(tx_done === 1'b0, "done at start");
    cyc(32);
    for (int i = 0; i <= n; i++) begin
      chk(tx_serial_out === s[i] && tx_done === 1'b0, "tx bit");
      cyc(64);
    end
    chk(tx_done === 1'b1 && tx_serial_out === 1'b1, "end of char");
    $display("tx case end");
  endtask : t_tx
  task automatic t_rx(input logic [1:0] len, input logic np, input logic two, input logic ev,
      input logic bad, input logic [7:0] d);
    logic [11:0] f;
    int k;
    f = mk(len, np, ev, bad, d, two, k);
    set_fmt(len, np, two, ev);
    @(posedge clk);
    term_frame <= f;
    term_bits <= k[3:0];
    term_go <= 1'b1;
    @(posedge clk) term_go <= 1'b0;
    for (k = 0; k < 1200 && rx_char_ready !== 1'b1; k++) cyc(1);
    if (k == 1200) hang();
    cyc(2);
    chk(rx_parallel_out === (d & (8'hFF >> (2'd3 - len))), "rx char");
    chk(rx_parallel_oe === 1'b1 && parity_error_flag === (bad & ~np), "rx flags");
    @(posedge clk);
    rx_ready_clear <= 1'b0;
    rx_output_enable_n <= 1'b1;
    cyc(3);
    chk(rx_char_ready === 1'b0 && rx_parallel_oe === 1'b0, "clear");
    @(posedge clk);
    rx_ready_clear <= 1'b1;
    rx_output_enable_n <= 1'b0;
    for (k = 0; k < 100 && term_busy; k++) cyc(1);
    if (k == 100) hang();
    $display("rx case end");
  endtask : t_rx
  task automatic t_glitch();
    @(posedge clk) glitch_n <= 1'b0;
    cyc(20);
    @(posedge clk) glitch_n <= 1'b1;
    cyc(1000);
    chk(rx_char_ready === 1'b0, "false start");
    $display("glitch end");
  endtask : t_glitch
  task automatic t_irq();
    rd(AST_ADDR_STAT, 8'h03);
    chk(irq === 1'b0, "irq masked");
    wr(AST_ADDR_MASK, 8'h01);
    cyc(1);
    chk(irq === 1'b1, "irq raised");
    wr(AST_ADDR_STAT, 8'h01);
    rd(AST_ADDR_STAT, 8'h02);
    chk(irq === 1'b0, "irq cleared");
    rd(4'h2, 8'h00);
    rd(AST_ADDR_MASK, 8'h01);
    $display("irq end");
  endtask : t_irq
  task automatic t_mreset();
    set_fmt(2'h3, 1'b0, 1'b1, 1'b0);
    @(posedge clk);
    tx_parallel_in <= 8'h00;
    tx_load_strobe <= 1'b1;
    @(posedge clk) tx_load_strobe <= 1'b0;
    cyc(200);
    @(posedge clk) master_reset <= 1'b1;
    @(posedge clk) master_reset <= 1'b0;
    cyc(1);
    chk(tx_serial_out === 1'b1 && tx_done === 1'b1 && tx_buffer_empty === 1'b1, "pin reset");
    rd(AST_ADDR_STAT, 8'h00);
    $display("master reset end");
  endtask : t_mreset
  // ****************
  // main sequence
  // ****************
  initial begin
    cyc(2);
    @(posedge clk) sys_rst <= 1'b0;
    cyc(1);
    chk(tx_serial_out === 1'b1 && tx_done === 1'b1 && tx_buffer_empty === 1'b1, "reset");
    rd(AST_ADDR_LIVE, 8'h13);
    for (int i = 0; i < 4; i++) t_tx(2'(i), i[0], i[1], i == 2, 8'hA5 ^ 8'(i));
    t_glitch();
    for (int i = 0; i < 4; i++) t_rx(2'(i), i[1], i[0], i == 0, i[0], 8'hD9 + 8'(i));
    t_irq();
    t_mreset();
    results();
  end
endmodule : ast_uart_tb_top
